// ==== core/dasr_pkg.sv ====
// Notes on behaviour
// - Signature write holds system reset asserted
// - Any other value releases held reset
// - Reads bit0 reset held, others zero
// - System reset never resets this block
// - Clock select 1/2/3 = 16/8/4 MHz
// - Finished bit starts user row flash transfer
// - Finished bit writable only with key
// - Clock request bit requests system clock
// - Disable clears clock request bit
// - Enable sets clock request bit automatically
// - Reset-active bit sticky, cleared by read
// - Held reset also shows in reset-active
// - Asleep bit shows idle or deeper sleep
// - NVM ready flag; debugger resets after
// - User row ready flag; debugger finishes after
// - Locked bit follows device lock state
// - CRC status one-hot 0/1/2/4
// - Disable resets interface and its state
`default_nettype none
package dasr_pkg;
  localparam logic [3:0] OFS_RESET_REQ = 4'h8;
  localparam logic [3:0] OFS_CLK_SEL = 4'h9;
  localparam logic [3:0] OFS_SYS_CTRL = 4'ha;
  localparam logic [3:0] OFS_SYS_STATUS = 4'hb;
  localparam logic [3:0] OFS_CRC_STATUS = 4'hc;

  localparam logic [7:0] RESET_SIGNATURE = 8'h59;

  localparam logic [1:0] CLK_SEL_RSVD = 2'h0;
  localparam logic [1:0] CLK_SEL_16M = 2'h1;
  localparam logic [1:0] CLK_SEL_8M = 2'h2;
  localparam logic [1:0] CLK_SEL_4M = 2'h3;
  localparam logic [1:0] RST_CLK_SEL = CLK_SEL_4M;

  localparam int BIT_CLK_REQ = 0;
  localparam int BIT_UROW_FIN = 1;
  localparam int BIT_LOCKED = 0;
  localparam int BIT_UROW_RDY = 2;
  localparam int BIT_NVM_RDY = 3;
  localparam int BIT_ASLEEP = 4;
  localparam int BIT_RST_ACT = 5;

  localparam logic [2:0] CRC_OFF = 3'h0;
  localparam logic [2:0] CRC_BUSY = 3'h1;
  localparam logic [2:0] CRC_OK = 3'h2;
  localparam logic [2:0] CRC_FAIL = 3'h4;

  localparam logic [7:0] RST_RDATA = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dasr_reg_req_t;

  typedef struct packed {
    logic in_reset;
    logic asleep;
    logic nvm_key;
    logic urow_key;
    logic locked;
  } dasr_sys_stat_t;

  typedef struct packed {
    logic enabled;
    logic busy;
    logic done;
    logic sig_ok;
  } dasr_crc_stat_t;

  typedef enum logic [1:0] {
    DASR_UROW_IDLE = 2'h0,
    DASR_UROW_START = 2'h1,
    DASR_UROW_BUSY = 2'h3
  } dasr_urow_st_t;
endpackage : dasr_pkg
`default_nettype wire

// ==== core/dasr_stat_enc.sv ====
`default_nettype none
module dasr_stat_enc (
  input wire dasr_pkg::dasr_sys_stat_t sys_i,
  input wire logic rst_held_i,
  input wire dasr_pkg::dasr_crc_stat_t crc_i,
  output logic [7:0] status_o,
  output logic [7:0] crc_o
);
  logic in_reset;
  logic [2:0] crc_code;

  // Held reset counts as system reset
  assign in_reset = sys_i.in_reset | rst_held_i;

  always_comb
  begin
    status_o = 8'h00;
    status_o[dasr_pkg::BIT_RST_ACT] = in_reset;
    status_o[dasr_pkg::BIT_ASLEEP] = sys_i.asleep;
    // Programming only while key active and system held in reset
    status_o[dasr_pkg::BIT_NVM_RDY] = sys_i.nvm_key & in_reset;
    status_o[dasr_pkg::BIT_UROW_RDY] = sys_i.urow_key & in_reset;
    status_o[dasr_pkg::BIT_LOCKED] = sys_i.locked;
  end

  always_comb
  begin
    if (!crc_i.enabled)
    begin
      crc_code = dasr_pkg::CRC_OFF;
    end
    else if (crc_i.busy || !crc_i.done)
    begin
      crc_code = dasr_pkg::CRC_BUSY;
    end
    else if (crc_i.sig_ok)
    begin
      crc_code = dasr_pkg::CRC_OK;
    end
    else
    begin
      crc_code = dasr_pkg::CRC_FAIL;
    end
    crc_o = {5'h00, crc_code};
  end
endmodule : dasr_stat_enc
`default_nettype wire

// ==== core/dasr_top.sv ====
`default_nettype none
module dasr_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic if_enable_i,
  input wire dasr_pkg::dasr_reg_req_t reg_req_i,
  input wire dasr_pkg::dasr_sys_stat_t sys_stat_i,
  input wire dasr_pkg::dasr_crc_stat_t crc_stat_i,
  input wire logic urow_done_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic sys_reset_req_o,
  output logic sys_clk_request_o,
  output logic [1:0] if_clk_sel_o,
  output logic urow_commit_o,
  output logic urow_busy_o
);
  logic rst_held_ff;
  logic nxt_rst_held;
  logic [1:0] clk_sel_ff;
  logic [1:0] nxt_clk_sel;
  logic clk_req_ff;
  logic nxt_clk_req;
  logic enable_d_ff;
  logic urow_fin_ff;
  logic nxt_urow_fin;
  logic rst_act_ff;
  logic nxt_rst_act;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic rvalid_ff;
  logic commit_ff;
  logic nxt_commit;
  dasr_pkg::dasr_urow_st_t urow_st_ff;
  dasr_pkg::dasr_urow_st_t nxt_urow_st;
  logic busy_ff;
  logic nxt_busy;
  logic [7:0] status_live;
  logic [7:0] crc_live;
  logic wr_req;
  logic wr_clk_sel;
  logic wr_sys_ctrl;
  logic rd_req;
  logic rd_status;
  logic if_reset;
  logic enable_rise;
  logic urow_fin_write;

  // Own reset plus disable; the system reset issued here never feeds back
  assign if_reset = rst_i | ~if_enable_i;
  assign enable_rise = if_enable_i & ~enable_d_ff;

  assign wr_req = reg_req_i.wr & (reg_req_i.addr == dasr_pkg::OFS_RESET_REQ);
  assign wr_clk_sel = reg_req_i.wr & (reg_req_i.addr == dasr_pkg::OFS_CLK_SEL);
  assign wr_sys_ctrl = reg_req_i.wr & (reg_req_i.addr == dasr_pkg::OFS_SYS_CTRL);
  assign rd_req = reg_req_i.rd;
  assign rd_status = reg_req_i.rd & (reg_req_i.addr == dasr_pkg::OFS_SYS_STATUS);

  // Without the key the finished bit is simply not writable
  assign urow_fin_write = wr_sys_ctrl & sys_stat_i.urow_key;

  dasr_stat_enc u_stat_enc (
    .sys_i(sys_stat_i),
    .rst_held_i(rst_held_ff),
    .crc_i(crc_stat_i),
    .status_o(status_live),
    .crc_o(crc_live)
  );

  // Previous enable level, for the enable edge
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      enable_d_ff <= 1'b0;
    end
    else
    begin
      enable_d_ff <= if_enable_i;
    end
  end

  always_comb
  begin
    nxt_rst_held = rst_held_ff;
    if (wr_req)
    begin
      if (reg_req_i.wdata == dasr_pkg::RESET_SIGNATURE)
      begin
        nxt_rst_held = 1'b1;
      end
      else
      begin
        nxt_rst_held = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (if_reset)
    begin
      rst_held_ff <= 1'b0;
    end
    else
    begin
      rst_held_ff <= nxt_rst_held;
    end
  end

  always_comb
  begin
    nxt_clk_sel = clk_sel_ff;
    // Reserved code dropped so the link never loses its clock
    if (wr_clk_sel && reg_req_i.wdata[1:0] != dasr_pkg::CLK_SEL_RSVD)
    begin
      nxt_clk_sel = reg_req_i.wdata[1:0];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (if_reset)
    begin
      clk_sel_ff <= dasr_pkg::RST_CLK_SEL;
    end
    else
    begin
      clk_sel_ff <= nxt_clk_sel;
    end
  end

  always_comb
  begin
    nxt_clk_req = clk_req_ff;
    // Enable edge beats a same-cycle write
    if (enable_rise)
    begin
      nxt_clk_req = 1'b1;
    end
    else if (wr_sys_ctrl)
    begin
      nxt_clk_req = reg_req_i.wdata[dasr_pkg::BIT_CLK_REQ];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (if_reset)
    begin
      clk_req_ff <= 1'b0;
    end
    else
    begin
      clk_req_ff <= nxt_clk_req;
    end
  end

  always_comb
  begin
    nxt_urow_fin = urow_fin_ff;
    if (urow_fin_write)
    begin
      nxt_urow_fin = reg_req_i.wdata[dasr_pkg::BIT_UROW_FIN];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (if_reset)
    begin
      urow_fin_ff <= 1'b0;
    end
    else
    begin
      urow_fin_ff <= nxt_urow_fin;
    end
  end

  // Flash transfer of the staged row; a new start is ignored while busy
  always_comb
  begin
    nxt_urow_st = urow_st_ff;
    nxt_commit = 1'b0;
    case (urow_st_ff)
      dasr_pkg::DASR_UROW_IDLE:
      begin
        if (urow_fin_write && reg_req_i.wdata[dasr_pkg::BIT_UROW_FIN])
        begin
          nxt_urow_st = dasr_pkg::DASR_UROW_START;
          nxt_commit = 1'b1;
        end
      end
      dasr_pkg::DASR_UROW_START:
      begin
        nxt_urow_st = dasr_pkg::DASR_UROW_BUSY;
      end
      dasr_pkg::DASR_UROW_BUSY:
      begin
        if (urow_done_i)
        begin
          nxt_urow_st = dasr_pkg::DASR_UROW_IDLE;
        end
      end
      default:
      begin
        nxt_urow_st = dasr_pkg::DASR_UROW_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (if_reset)
    begin
      urow_st_ff <= dasr_pkg::DASR_UROW_IDLE;
    end
    else
    begin
      urow_st_ff <= nxt_urow_st;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (if_reset)
    begin
      commit_ff <= 1'b0;
    end
    else
    begin
      commit_ff <= nxt_commit;
    end
  end

  // Busy registered so the status output is glitch free
  assign nxt_busy = (nxt_urow_st != dasr_pkg::DASR_UROW_IDLE);

  always_ff @(posedge mclk_i)
  begin
    if (if_reset)
    begin
      busy_ff <= 1'b0;
    end
    else
    begin
      busy_ff <= nxt_busy;
    end
  end

  // Sticky so a short system reset is still seen; the set beats the read-clear
  always_comb
  begin
    nxt_rst_act = rst_act_ff;
    if (status_live[dasr_pkg::BIT_RST_ACT])
    begin
      nxt_rst_act = 1'b1;
    end
    else if (rd_status)
    begin
      nxt_rst_act = 1'b0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (if_reset)
    begin
      rst_act_ff <= 1'b0;
    end
    else
    begin
      rst_act_ff <= nxt_rst_act;
    end
  end

  always_comb
  begin
    nxt_rdata = 8'h00;
    case (reg_req_i.addr)
      dasr_pkg::OFS_RESET_REQ:
      begin
        nxt_rdata = {7'h00, rst_held_ff};
      end
      dasr_pkg::OFS_CLK_SEL:
      begin
        nxt_rdata = {6'h00, clk_sel_ff};
      end
      dasr_pkg::OFS_SYS_CTRL:
      begin
        nxt_rdata = {6'h00, urow_fin_ff, clk_req_ff};
      end
      dasr_pkg::OFS_SYS_STATUS:
      begin
        // Live bits as sampled now; reset-active also from the sticky copy
        nxt_rdata = status_live;
        nxt_rdata[dasr_pkg::BIT_RST_ACT] = rst_act_ff | status_live[dasr_pkg::BIT_RST_ACT];
      end
      dasr_pkg::OFS_CRC_STATUS:
      begin
        nxt_rdata = crc_live;
      end
      default:
      begin
        nxt_rdata = 8'h00;
      end
    endcase
  end

  // Read data is captured so it stays stable after the request ends
  always_ff @(posedge mclk_i)
  begin
    if (if_reset)
    begin
      rdata_ff <= dasr_pkg::RST_RDATA;
    end
    else if (rd_req)
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Valid pulses for every read, mapped or not
  always_ff @(posedge mclk_i)
  begin
    if (if_reset)
    begin
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= rd_req;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign sys_reset_req_o = rst_held_ff;
  assign sys_clk_request_o = clk_req_ff;
  assign if_clk_sel_o = clk_sel_ff;
  assign urow_commit_o = commit_ff;
  assign urow_busy_o = busy_ff;
endmodule : dasr_top
`default_nettype wire

// ==== dv/dasr_assertions.sv ====
`default_nettype none
module dasr_assertions (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic if_enable_i,
  input wire dasr_pkg::dasr_reg_req_t reg_req_i,
  input wire dasr_pkg::dasr_sys_stat_t sys_stat_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic sys_reset_req_o,
  input wire logic sys_clk_request_o,
  input wire logic [1:0] if_clk_sel_o,
  input wire logic urow_commit_o,
  input wire logic urow_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr;
  logic rd;
  logic go;
  logic [3:0] a;
  logic [7:0] d;
  assign a = reg_req_i.addr;
  assign d = reg_req_i.wdata;
  assign wr = reg_req_i.wr && if_enable_i;
  assign rd = reg_req_i.rd && if_enable_i;
  // Only an idle engine holding the key may start
  assign go = wr && a == 4'ha && d[1] && sys_stat_i.urow_key && !urow_busy_o;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  sequence commit_pulse;
    urow_commit_o && urow_busy_o ##1 !urow_commit_o;
  endsequence
  AST_RST_REQ: assert property (wr && a == 4'h8 |=> sys_reset_req_o == ($past(d) == 8'h59))
    else $error("bad reset request");
  AST_RST_RD: assert property (rd && !wr && a == 4'h8 |=> reg_rvalid_o
    && reg_rdata_o == {7'h00, $past(sys_reset_req_o)}) else $error("bad reset readback");
  AST_CLK_SEL: assert property (wr && a == 4'h9 |=> if_clk_sel_o ==
    ($past(d[1:0]) == 2'h0 ? $past(if_clk_sel_o) : $past(d[1:0]))) else $error("bad clock select");
  AST_DISABLE: assert property (!if_enable_i |=> !sys_clk_request_o && !sys_reset_req_o
    && if_clk_sel_o == 2'h3 && !urow_busy_o) else $error("state kept while disabled");
  AST_EN_REQ: assert property ($rose(if_enable_i) |=> sys_clk_request_o)
    else $error("no clock request on enable");
  AST_CLK_REQ: assert property (wr && a == 4'ha && !$rose(if_enable_i) && !$past(rst_i)
    |=> sys_clk_request_o == $past(d[0])) else $error("bad clock request");
  AST_UROW_GO: assert property (go |=> commit_pulse)
    else $error("bad user row start");
  AST_UROW_KEY: assert property (urow_commit_o |-> $past(go))
    else $error("user row start without key");
endmodule : dasr_assertions

bind dasr_top dasr_assertions u_chk (.mclk_i, .rst_i, .if_enable_i, .reg_req_i, .sys_stat_i,
  .reg_rdata_o, .reg_rvalid_o, .sys_reset_req_o, .sys_clk_request_o, .if_clk_sel_o,
  .urow_commit_o, .urow_busy_o);
`default_nettype wire

// ==== dv/dasr_sys_model.sv ====
`default_nettype none
module dasr_sys_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic commit_i,
  input wire logic [3:0] lat_i,
  output logic in_reset_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_ff;
  // Falling edge, like every other stimulus, to keep clear of the sampling edge
  always @(negedge mclk_i)
  begin
    in_reset_o <= req_i;
    done_o <= cnt_ff == 4'h1;
    if (rst_i || commit_i)
      cnt_ff <= rst_i ? 4'h0 : lat_i;
    else if (cnt_ff != 4'h0)
      cnt_ff <= cnt_ff - 4'h1;
  end
endmodule : dasr_sys_model
`default_nettype wire

// ==== dv/tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk;
  logic rst;
  logic en;
  logic done;
  logic in_rst;
  logic [3:0] st;
  logic [3:0] lat;
  logic [7:0] rdata;
  logic rvalid;
  logic sreq;
  logic creq;
  logic [1:0] sel;
  logic commit;
  logic busy;
  dasr_pkg::dasr_reg_req_t req;
  dasr_pkg::dasr_crc_stat_t crc;
  logic [3:0] crc_w [5] = '{4'h0, 4'hc, 4'h8, 4'hb, 4'ha};
  logic [7:0] crc_e [5] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h04};
  int bad_count;
  int cmp_count;

  dasr_top dut (.mclk_i(mclk), .rst_i(rst), .if_enable_i(en), .reg_req_i(req),
    .sys_stat_i({in_rst, st}), .crc_stat_i(crc), .urow_done_i(done), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .sys_reset_req_o(sreq), .sys_clk_request_o(creq),
    .if_clk_sel_o(sel), .urow_commit_o(commit), .urow_busy_o(busy));
  dasr_sys_model sysm (.mclk_i(mclk), .rst_i(rst), .req_i(sreq), .commit_i(commit),
    .lat_i(lat), .in_reset_o(in_rst), .done_o(done));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [8:0] g, input logic [8:0] e);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : check

  // One idle cycle after each access so a strobe never changes twice at one edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    req = {w, ~w, a, d};
    @(negedge mclk);
    req = '0;
  endtask : acc

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    check({rvalid, rdata}, {1'b1, e});
  endtask : rdc

  task automatic wrc(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
    acc(1'b1, a, d);
    rdc(a, e);
  endtask : wrc

  initial
  begin
    rst = 1'b1;
    en = 1'b1;
    req = '0;
    st = 4'h1;
    crc = '0;
    lat = 4'h1;
    bad_count = 0;
    cmp_count = 0;
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    rdc(4'h8, 8'h00);
    rdc(4'h9, 8'h03);
    rdc(4'ha, 8'h01);
    rdc(4'hb, 8'h01);
    rdc(4'hc, 8'h00);
    $display("reset values done");
    wrc(4'h9, 8'h01, 8'h01);
    wrc(4'h9, 8'h02, 8'h02);
    wrc(4'h9, 8'h00, 8'h02);
    wrc(4'h9, 8'hff, 8'h03);
    $display("clock select done");
    st = 4'h7;
    acc(1'b1, 4'h8, 8'h59);
    check({8'h00, sreq}, 9'h001);
    rdc(4'h8, 8'h01);
    rdc(4'hb, 8'h2d);
    rdc(4'ha, 8'h01);
    st = 4'he;
    wrc(4'hb, 8'hff, 8'h3c);
    acc(1'b1, 4'h8, 8'h00);
    check({8'h00, sreq}, 9'h000);
    rdc(4'hb, 8'h30);
    rdc(4'hb, 8'h10);
    $display("system reset done");
    wrc(4'ha, 8'h00, 8'h00);
    check({8'h00, creq}, 9'h000);
    wrc(4'ha, 8'h01, 8'h01);
    acc(1'b1, 4'h9, 8'h01);
    acc(1'b1, 4'h8, 8'h59);
    en = 1'b0;
    @(negedge mclk);
    check({5'h00, creq, sreq, sel}, 9'h003);
    en = 1'b1;
    repeat (2) @(negedge mclk);
    check({8'h00, creq}, 9'h001);
    $display("clock request done");
    st = 4'h0;
    acc(1'b1, 4'ha, 8'h03);
    check({7'h00, commit, busy}, 9'h000);
    rdc(4'ha, 8'h01);
    st = 4'h2;
    for (int i = 0; i < 2; i++)
    begin
      lat = i[0] ? 4'h9 : 4'h1;
      acc(1'b1, 4'ha, 8'h03);
      check({7'h00, commit, busy}, 9'h003);
      acc(1'b1, 4'ha, 8'h03);
      check({8'h00, commit}, 9'h000);
      for (int n = 0; n < 40 && busy !== 1'b0; n++)
        @(negedge mclk);
      check({8'h00, busy}, 9'h000);
      if (busy !== 1'b0)
        give_verdict();
      rdc(4'ha, 8'h03);
    end
    $display("user row done");
    for (int i = 0; i < 5; i++)
    begin
      crc = crc_w[i];
      rdc(4'hc, crc_e[i]);
    end
    $display("crc status done");
    give_verdict();
  end

  initial
  begin
    repeat (4000) @(posedge mclk);
    bad_count++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
